// ### dv/gpt_pin_model.sv
// external clock and gate pin driver standing beside the timer block
`timescale 1ns/10ps
module gpt_pin_model (
    input  wire logic       ref_clk_i,
    output logic      [4:0] pin_o
);
    initial pin_o = 5'h00;
    // edges spaced well past the three-flop filter so none is swallowed
    task automatic pulse(input int idx, input int n);
        repeat (n)
        begin
            repeat (5) @(posedge ref_clk_i);
            pin_o[idx] <= 1'b1;
            repeat (5) @(posedge ref_clk_i);
            pin_o[idx] <= 1'b0;
        end
    endtask : pulse
    task automatic level(input int idx, input logic v);
        @(posedge ref_clk_i);
        pin_o[idx] <= v;
    endtask : level
endmodule : gpt_pin_model

// ### dv/gpt_timers_sva.sv
// assertion checker for the general purpose timer block
`timescale 1ns/10ps
module gpt_timers_sva (
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic [4:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic        sleep_i,
    input wire logic [15:0] rdata_o,
    input wire logic [4:0]  event_o,
    input wire logic        adc_trig_o,
    input wire logic [15:0] tb_a_low_o,
    input wire logic [15:0] tb_a_high_o
);
    logic       pair_reg;
    logic [2:0] quiet_reg;
    // shadow of the pair bit, since the checker cannot see the control bank
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            pair_reg <= 1'b0;
        else if (wr_i && addr_i == 5'h01)
            pair_reg <= wdata_i[3];
        if (rst_i || !sleep_i || wr_i)
            quiet_reg <= 3'h0;
        else if (quiet_reg != 3'h7)
            quiet_reg <= quiet_reg + 3'h1;
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    a_adc_follows: assert property (adc_trig_o == event_o[2])
        else $error("converter trigger differs from pair event");
    a_low_steps: assert property (!$past(wr_i) && !$past(wr_i, 2) && !$past(wr_i, 3)
        && $changed(tb_a_low_o) |-> tb_a_low_o == $past(tb_a_low_o) + 16'h0001
        || tb_a_low_o == 16'h0000) else $error("low count jumped");
    a_high_steps: assert property (!$past(wr_i) && !$past(wr_i, 2) && !$past(wr_i, 3)
        && $changed(tb_a_high_o) |-> tb_a_high_o == $past(tb_a_high_o) + 16'h0001
        || tb_a_high_o == 16'h0000) else $error("high count jumped");
    a_pair_carry: assert property (pair_reg && $past(pair_reg, 3) && !$past(wr_i)
        && !$past(wr_i, 2) && $changed(tb_a_high_o) |-> $changed(tb_a_low_o))
        else $error("high word moved without low word carry");
    a_std_ctrl_bits: assert property (rd_i && addr_i == 5'h00 |=>
        (rdata_o & ~gpt_pkg::STANDALONE_CTRL_MASK) == 16'h0000) else $error("bad ctrl bits");
    a_odd_ctrl_bits: assert property (rd_i && addr_i == 5'h02 |=>
        (rdata_o & ~gpt_pkg::ODD_CTRL_MASK) == 16'h0000) else $error("bad odd ctrl bits");
    a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside read answer");
    a_sleep_hold: assert property (quiet_reg >= 3'h4 |-> $stable(tb_a_low_o))
        else $error("timer2 counted in sleep");
endmodule : gpt_timers_sva
bind gpt_timers gpt_timers_sva u_sva (.ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .sleep_i, .rdata_o, .event_o, .adc_trig_o, .tb_a_low_o, .tb_a_high_o);

// ### dv/tb.sv
// self-checking bench for the general purpose timer block
`timescale 1ns/10ps
module tb;
    logic        ref_clk_i, rst_i, wr_i, rd_i, idle_i, sleep_i, adc;
    logic [4:0]  addr_i, event_o, pins;
    logic [15:0] wdata_i, rdata_o, lo, hi, v;
    int          err_total = 0, total_checks = 0, cyc = 0, n, ev0 = 0;
    gpt_timers dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .idle_i(idle_i), .sleep_i(sleep_i), .ext_clock_pin_i(pins),
        .rdata_o(rdata_o), .event_o(event_o), .adc_trig_o(adc), .tb_a_low_o(lo),
        .tb_a_high_o(hi));
    gpt_pin_model pin (.ref_clk_i(ref_clk_i), .pin_o(pins));
    initial
    begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    // hang guard, far above the few thousand cycles the run needs
    always @(posedge ref_clk_i)
    begin
        cyc <= cyc + 1;
        if (event_o[0] === 1'b1)
            ev0 <= ev0 + 1;
        if (cyc == 20000)
        begin
            err_total++;
            summarize();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one idle cycle after each strobe, so no strobe is set twice in a time step
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        @(posedge ref_clk_i);
        d = rdata_o;
    endtask : rd
    task automatic wait_ev(input int idx);
        n = 0;
        do
        begin
            @(posedge ref_clk_i);
            n++;
        end
        while (event_o[idx] !== 1'b1 && n < 2000);
    endtask : wait_ev
    task automatic t_regs();
        logic [4:0]  a [6] = '{5'h00, 5'h02, 5'h08, 5'h10, 5'h13, 5'h1F};
        logic [15:0] e [6] = '{16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000};
        logic [15:0] m [3] = '{16'h2076, 16'h207A, 16'h2072};
        for (int k = 0; k < 6; k++)
        begin
            rd(a[k], v);
            chk("reset value", v, e[k]);
        end
        for (int k = 0; k < 3; k++)
        begin
            wr(k[4:0], 16'h7FFF);
            rd(k[4:0], v);
            chk("ctrl bits", v, m[k]);
            wr(k[4:0], 16'h0000);
        end
        wr(5'h1F, 16'hFFFF);
        rd(5'h1F, v);
        chk("unmapped", v, 16'h0000);
    endtask : t_regs
    task automatic t_period();
        int div [4] = '{1, 8, 64, 256};
        wr(5'h08, 16'h0000);
        wr(5'h10, 16'h0002);
        for (int k = 0; k < 4; k++)
        begin
            wr(5'h00, 16'h8000 | (k[15:0] << 4));
            wait_ev(0);
            wait_ev(0);
            chk("interval", n, 3 * div[k]);
        end
        wr(5'h00, 16'h0000);
    endtask : t_period
    task automatic t_ext();
        wr(5'h08, 16'h0000);
        wr(5'h10, 16'h0003);
        wr(5'h00, 16'h8006);
        wr(5'h08, 16'h1234);
        n = ev0;
        pin.pulse(0, 3);
        rd(5'h08, v);
        chk("ext count", v, 16'h0003);
        pin.pulse(0, 1);
        repeat (6) @(posedge ref_clk_i);
        chk("ext events", ev0 - n, 1);
        wr(5'h00, 16'h0000);
    endtask : t_ext
    task automatic t_gate();
        wr(5'h08, 16'h0000);
        wr(5'h10, 16'hFFFF);
        wr(5'h00, 16'h8040);
        n = ev0;
        pin.level(0, 1'b1);
        repeat (20) @(posedge ref_clk_i);
        pin.level(0, 1'b0);
        repeat (8) @(posedge ref_clk_i);
        chk("gate event", ev0 - n, 1);
        rd(5'h08, v);
        chk("gate count", v >= 16'h0012 && v <= 16'h0018, 1);
        wr(5'h00, 16'h0000);
    endtask : t_gate
    task automatic t_idle();
        wr(5'h09, 16'h0000);
        wr(5'h11, 16'hFFFF);
        wr(5'h01, 16'hA000);
        for (int k = 0; k < 3; k++)
        begin
            idle_i <= (k < 2);
            sleep_i <= (k == 2);
            if (k == 1)
                wr(5'h01, 16'h8000);
            repeat (4) @(posedge ref_clk_i);
            v = lo;
            repeat (10) @(posedge ref_clk_i);
            chk("idle or sleep", lo, (k == 1) ? v + 16'h000A : v);
        end
        sleep_i <= 1'b0;
        wr(5'h01, 16'h0000);
    endtask : t_idle
    task automatic t_pair();
        wr(5'h09, 16'hFFFE);
        wr(5'h0A, 16'h0000);
        wr(5'h11, 16'h0001);
        wr(5'h12, 16'h0001);
        wr(5'h02, 16'h8002); // odd control must not steer the pair
        wr(5'h01, 16'h8008);
        wait_ev(2);
        chk("pair match time", n, 4);
        chk("pair event bits", {event_o[1], adc}, 2'b01);
        chk("pair high word", hi, 16'h0000);
        wr(5'h01, 16'h0000);
        wr(5'h02, 16'h0000);
    endtask : t_pair
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    initial
    begin
        {rst_i, wr_i, rd_i, idle_i, sleep_i, addr_i, wdata_i} = {1'b1, 25'h0};
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        t_regs();
        t_period();
        t_ext();
        t_gate();
        t_idle();
        t_pair();
        summarize();
    end
endmodule : tb

// ### inc/gpt_pkg.sv
// gpt_pkg: constants shared by the general purpose timer block
package gpt_pkg;

    localparam int NUM_TIMERS = 5;
    localparam int ADDR_W     = 5;
    localparam int DATA_W     = 16;

    // register indices: control, count and period banks, one word per timer
    localparam logic [4:0] CTRL_BASE   = 5'h00;
    localparam logic [4:0] COUNT_BASE  = 5'h08;
    localparam logic [4:0] PERIOD_BASE = 5'h10;

    // control field positions
    localparam int RUN_BIT       = 15;
    localparam int IDLE_STOP_BIT = 13;
    localparam int GATE_EN_BIT   = 6;
    localparam int PRESCALE_HI   = 5;
    localparam int PRESCALE_LO   = 4;
    localparam int PAIR_MODE_BIT = 3;
    localparam int EXT_SYNC_BIT  = 2;
    localparam int CLK_SRC_BIT   = 1;

    // implemented control bits per timer kind, the rest read zero
    localparam logic [15:0] STANDALONE_CTRL_MASK = 16'hA076;
    localparam logic [15:0] EVEN_CTRL_MASK       = 16'hA07A;
    localparam logic [15:0] ODD_CTRL_MASK        = 16'hA072;

    localparam logic [15:0] CTRL_RESET   = 16'h0000;
    localparam logic [15:0] COUNT_RESET  = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;

    // prescaler terminal counts (divide ratio minus one)
    localparam logic [7:0] PRESCALE_TERM_1   = 8'h00;
    localparam logic [7:0] PRESCALE_TERM_8   = 8'h07;
    localparam logic [7:0] PRESCALE_TERM_64  = 8'h3F;
    localparam logic [7:0] PRESCALE_TERM_256 = 8'hFF;

endpackage : gpt_pkg

// ### verilog/gpt_timers.sv
// gpt_timers: one standalone timer and two pairable 16/32-bit timer pairs
//
// Overview of operation
// - standalone timer is 16-bit: timer, sync counter or async counter
// - run bit 15 starts counting when one, stops when zero
// - idle-stop bit 13 halts timer in idle; zero keeps it running
// - gate bit 6 gates accumulation on internal clock; ignored on external clock
// - prescale field divides by 256, 64, 8 or 1 for codes 11, 10, 01, 00
// - sync bit 2 synchronises external clock; ignored on internal clock
// - clock-source bit 1 picks external pin rising edges or internal clock
// - count writes ignored while external clock selected and standalone timer runs
// - standalone flag on period match or gate falling edge
// - standalone timer may keep running in idle and sleep
// - paired: even timer is low word, odd timer high word
// - paired: odd control ignored, even control and pins used
// - paired: match event reported through odd timer's flag
// - paired: odd period is upper half, even period lower half
// - paired: full 32-bit count compared with 32-bit period
// - paired: live count held in odd/even count registers
// - pairable timers: all 16-bit modes but async, plus 32-bit modes
// - first pair drives converter trigger, second pair does not
// - first pair's counts exported as capture/compare time base
// - pair bit 3 of even control joins the two timers into 32 bits
`timescale 1ns/10ps

module gpt_timers (
    input  wire logic                          ref_clk_i,
    input  wire logic                          rst_i,
    input  wire logic [gpt_pkg::ADDR_W-1:0]    addr_i,
    input  wire logic [gpt_pkg::DATA_W-1:0]    wdata_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    input  wire logic                          idle_i,
    input  wire logic                          sleep_i,
    input  wire logic [gpt_pkg::NUM_TIMERS-1:0] ext_clock_pin_i,
    output logic      [gpt_pkg::DATA_W-1:0]    rdata_o,
    output logic      [gpt_pkg::NUM_TIMERS-1:0] event_o,
    output logic                               adc_trig_o,
    output logic      [gpt_pkg::DATA_W-1:0]    tb_a_low_o,
    output logic      [gpt_pkg::DATA_W-1:0]    tb_a_high_o
);

    localparam int N = gpt_pkg::NUM_TIMERS;

    typedef struct packed {
        logic [N-1:0][15:0] ctrl;
        logic [N-1:0][15:0] cnt;
        logic [N-1:0][15:0] per;
        logic [N-1:0][7:0]  psc;
        logic [N-1:0]       s1;
        logic [N-1:0]       s2;
        logic [N-1:0]       s3;
        logic [N-1:0]       flt;
        logic [N-1:0]       evt;
        logic               adc;
        logic [15:0]        rdata;
    } gpt_state_t;

    gpt_state_t state_reg;
    gpt_state_t state_next;

    function automatic logic [7:0] gpt_prescale_term(input logic [1:0] code);
        case (code)
            2'b11:   gpt_prescale_term = gpt_pkg::PRESCALE_TERM_256;
            2'b10:   gpt_prescale_term = gpt_pkg::PRESCALE_TERM_64;
            2'b01:   gpt_prescale_term = gpt_pkg::PRESCALE_TERM_8;
            default: gpt_prescale_term = gpt_pkg::PRESCALE_TERM_1;
        endcase
    endfunction : gpt_prescale_term

    function automatic logic [15:0] gpt_ctrl_mask(input int idx);
        if (idx == 0)
            gpt_ctrl_mask = gpt_pkg::STANDALONE_CTRL_MASK;
        else if (idx == 1 || idx == 3)
            gpt_ctrl_mask = gpt_pkg::EVEN_CTRL_MASK;
        else
            gpt_ctrl_mask = gpt_pkg::ODD_CTRL_MASK;
    endfunction : gpt_ctrl_mask

    // one word per timer in each bank, so a hit is base plus timer index
    function automatic logic gpt_addr_hit(
        input logic [4:0] base,
        input int         idx,
        input logic [4:0] addr
    );
        gpt_addr_hit = (addr == base + 5'(idx));
    endfunction : gpt_addr_hit

    always_comb
    begin
        logic [N-1:0] rise;
        logic [N-1:0] fall;
        logic [15:0]  ctl;
        logic         wide;
        logic         skip;
        logic         clock_source_select;
        logic         gated;
        logic         async_cnt;
        logic         run;
        logic         src;
        logic         tick;
        logic [31:0]  cur32;
        logic [31:0]  per32;
        int           hi;
        rise       = '0;
        fall       = '0;
        ctl        = '0;
        wide       = 1'b0;
        skip       = 1'b0;
        clock_source_select        = 1'b0;
        gated      = 1'b0;
        async_cnt  = 1'b0;
        run        = 1'b0;
        src        = 1'b0;
        tick       = 1'b0;
        cur32      = '0;
        per32      = '0;
        hi         = 0;
        state_next = state_reg;
        state_next.evt   = '0;
        state_next.adc   = 1'b0;
        state_next.rdata = '0;

        // pins: three stages, a change is taken once stages two and three agree
        state_next.s1 = ext_clock_pin_i;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        for (int j = 0; j < N; j++)
        begin
            if (state_reg.s2[j] == state_reg.s3[j])
            begin
                state_next.flt[j] = state_reg.s2[j];
                rise[j] = state_reg.s2[j] & ~state_reg.flt[j];
                fall[j] = ~state_reg.s2[j] & state_reg.flt[j];
            end
        end

        for (int i = 0; i < N; i++)
        begin
            hi   = (i < 3) ? 2 : 4;
            skip = (i == 2 && state_reg.ctrl[1][gpt_pkg::PAIR_MODE_BIT]) ||
                   (i == 4 && state_reg.ctrl[3][gpt_pkg::PAIR_MODE_BIT]);
            if (!skip)
            begin
                ctl  = state_reg.ctrl[i];
                wide = (i == 1 || i == 3) && ctl[gpt_pkg::PAIR_MODE_BIT];
                clock_source_select  = ctl[gpt_pkg::CLK_SRC_BIT];
                // only the standalone timer has an unsynchronised mode
                async_cnt = (i == 0) && clock_source_select && !ctl[gpt_pkg::EXT_SYNC_BIT];
                // internal clock stops in sleep; only the async count survives it
                run = ctl[gpt_pkg::RUN_BIT] &&
                      !(idle_i && ctl[gpt_pkg::IDLE_STOP_BIT]) &&
                      !(sleep_i && !async_cnt);
                gated = !clock_source_select && ctl[gpt_pkg::GATE_EN_BIT];
                src = clock_source_select ? rise[i] : (gated ? state_reg.flt[i] : 1'b1);
                tick = 1'b0;
                if (!ctl[gpt_pkg::RUN_BIT])
                    state_next.psc[i] = '0;
                else if (run && src)
                begin
                    if (state_reg.psc[i] >= gpt_prescale_term(
                            ctl[gpt_pkg::PRESCALE_HI:gpt_pkg::PRESCALE_LO]))
                    begin
                        state_next.psc[i] = '0;
                        tick = 1'b1;
                    end
                    else
                        state_next.psc[i] = state_reg.psc[i] + 8'h01;
                end

                // falling gate edge ends an accumulation and flags it
                if (gated && run && fall[i])
                    state_next.evt[wide ? hi : i] = 1'b1;

                if (tick && wide)
                begin
                    cur32 = {state_reg.cnt[hi], state_reg.cnt[i]};
                    per32 = {state_reg.per[hi], state_reg.per[i]};
                    if (cur32 == per32)
                    begin
                        cur32 = '0;
                        state_next.evt[hi] = 1'b1;
                    end
                    else
                        cur32 = cur32 + 32'h0000_0001;
                    state_next.cnt[hi] = cur32[31:16];
                    state_next.cnt[i]  = cur32[15:0];
                end
                else if (tick)
                begin
                    if (state_reg.cnt[i] == state_reg.per[i])
                    begin
                        state_next.cnt[i] = '0;
                        state_next.evt[i] = 1'b1;
                    end
                    else
                        state_next.cnt[i] = state_reg.cnt[i] + 16'h0001;
                end
            end
        end

        // converter trigger from the first pair's odd timer event
        state_next.adc = state_next.evt[2];

        // register writes land after counting, so software wins a same-cycle count
        if (wr_i)
        begin
            for (int i = 0; i < N; i++)
            begin
                if (gpt_addr_hit(gpt_pkg::CTRL_BASE, i, addr_i))
                    state_next.ctrl[i] = wdata_i & gpt_ctrl_mask(i);
                if (gpt_addr_hit(gpt_pkg::PERIOD_BASE, i, addr_i))
                    state_next.per[i] = wdata_i;
                if (gpt_addr_hit(gpt_pkg::COUNT_BASE, i, addr_i) &&
                    !(i == 0 && state_reg.ctrl[0][gpt_pkg::CLK_SRC_BIT] &&
                      state_reg.ctrl[0][gpt_pkg::RUN_BIT]))
                    state_next.cnt[i] = wdata_i;
            end
        end

        // unmapped addresses read as zero
        if (rd_i)
        begin
            for (int i = 0; i < N; i++)
            begin
                if (gpt_addr_hit(gpt_pkg::CTRL_BASE, i, addr_i))
                    state_next.rdata = state_reg.ctrl[i];
                if (gpt_addr_hit(gpt_pkg::COUNT_BASE, i, addr_i))
                    state_next.rdata = state_reg.cnt[i];
                if (gpt_addr_hit(gpt_pkg::PERIOD_BASE, i, addr_i))
                    state_next.rdata = state_reg.per[i];
            end
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            state_reg.ctrl  <= {N{gpt_pkg::CTRL_RESET}};
            state_reg.cnt   <= {N{gpt_pkg::COUNT_RESET}};
            state_reg.per   <= {N{gpt_pkg::PERIOD_RESET}};
            state_reg.psc   <= '0;
            state_reg.s1    <= '0;
            state_reg.s2    <= '0;
            state_reg.s3    <= '0;
            state_reg.flt   <= '0;
            state_reg.evt   <= '0;
            state_reg.adc   <= 1'b0;
            state_reg.rdata <= '0;
        end
        else
            state_reg <= state_next;
    end

    assign rdata_o     = state_reg.rdata;
    assign event_o     = state_reg.evt;
    assign adc_trig_o  = state_reg.adc;
    assign tb_a_low_o  = state_reg.cnt[1];
    assign tb_a_high_o = state_reg.cnt[2];

endmodule : gpt_timers
